/* File: asrr_pkg.sv */
package asrr_pkg;
   localparam int NUM_REGS = 18;
   localparam int RES_DATA_BYTES = 3;
   // Register offsets
   localparam logic [4:0] OFS_DEVICE_IDENTITY = 5'h00;
   localparam logic [4:0] OFS_DEVICE_STATUS_FLAGS = 5'h01;
   localparam logic [4:0] OFS_INPUT_CHANNEL_SELECT = 5'h02;
   localparam logic [4:0] OFS_AMPLIFIER_GAIN_CONFIG = 5'h03;
   localparam logic [4:0] OFS_CONVERSION_RATE_FILTER = 5'h04;
   localparam logic [4:0] OFS_REFERENCE_CONTROL = 5'h05;
   localparam logic [4:0] OFS_EXCITATION_CURRENT_MAGNITUDE = 5'h06;
   localparam logic [4:0] OFS_EXCITATION_CURRENT_ROUTING = 5'h07;
   localparam logic [4:0] OFS_BIAS_VOLTAGE_ENABLE = 5'h08;
   localparam logic [4:0] OFS_SYSTEM_CONTROL = 5'h09;
   localparam logic [4:0] OFS_OFFSET_CAL_BYTE0 = 5'h0a;
   localparam logic [4:0] OFS_OFFSET_CAL_BYTE1 = 5'h0b;
   localparam logic [4:0] OFS_OFFSET_CAL_BYTE2 = 5'h0c;
   localparam logic [4:0] OFS_GAIN_CAL_BYTE0 = 5'h0d;
   localparam logic [4:0] OFS_GAIN_CAL_BYTE1 = 5'h0e;
   localparam logic [4:0] OFS_GAIN_CAL_BYTE2 = 5'h0f;
   localparam logic [4:0] OFS_GPIO_DATA_DIRECTION = 5'h10;
   localparam logic [4:0] OFS_GPIO_PIN_CONFIG = 5'h11;
   // Values after reset, highest offset first; identity slot is filled by the module
   localparam logic [NUM_REGS-1:0][7:0] REG_RESET = {
      8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h10,
      8'h00, 8'hff, 8'h00, 8'h10, 8'h14, 8'h00, 8'h01, 8'h80, 8'h00};
   // Bits that a register write may change
   localparam logic [NUM_REGS-1:0][7:0] REG_WR_MASK = {
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h80, 8'h00};
   // Bits whose change restarts a running conversion
   localparam logic [NUM_REGS-1:0][7:0] REG_RESTART_MASK = {
      8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'he0,
      8'h00, 8'hff, 8'h0f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'h00, 8'h00};
   // Field positions
   localparam int SYS_STATUS_BYTE_ENABLE_BIT = 0;
   localparam int SYS_CRC_ENABLE_BIT = 1;
   localparam logic [2:0] PFX_REGISTER_READ_CMD = 3'b001;
   localparam logic [2:0] PFX_REGISTER_WRITE_CMD = 3'b010;

   typedef struct packed {
      logic [7:0] status;
      logic [23:0] data;
      logic [7:0] crc;
   } asrr_result_type;

   typedef struct packed {
      logic [4:0] addr;
      logic [7:0] data;
   } asrr_wreq_type;

   typedef enum logic [2:0] {
      M_DIRECT, M_RDATA, M_REGISTER_READ_CMD_HDR, M_REGISTER_READ_CMD, M_REGISTER_WRITE_CMD_HDR, M_REGISTER_WRITE_CMD
   } asrr_mode_type;
endpackage

/* File: asrr_top.sv */
// Notes on behaviour
// - Read-data command returns the snapshot, never a half-updated result.
// - Result MSB appears on first rising SCLK after the read-data command.
// - Result field is optional status, three data bytes, optional CRC.
// - During a read-data read, commands are ignored until the field ends or CS rises.
// - After the last byte the same field repeats from its first byte.
// - With CS low and before the first rising SCLK, serial out falls together with the result-ready pin.
// - In direct reads, every input byte boundary is decoded as a command.
// - Register-read or read-data mid direct read abandons the current result read.
// - Response to a mid-read command starts on the next rising SCLK.
// - A register write during a direct read leaves the result stream intact.
// - A written register byte that changes a setting restarts conversion with new settings when running.
// - Output byte order is circular; three input bytes wrap a plain field.
// - With CS high the shared serial out pin is released.
// - The result-ready pin is always driven.
// - On CS fall serial out shows low if a result waits, else high.
// - Eighteen 8-bit registers, reached only by register commands.
// - Reset loads every register with its default.
// - Block writes apply each byte as it arrives.
// - Register read: 001 plus start address, then count minus one.
// - Register write: 010 plus start address, count minus one, data MSB first.
// - Restart only when the value changes and a conversion is running.
module asrr_top #(
   parameter logic [2:0] DEV_CODE = 3'h5, // Arbitrary identity value
   parameter logic [7:0] RDATA_OPCODE = 8'h12,
   parameter logic [7:0] CRC_POLY = 8'h07
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   output logic serial_out_ready_n,
   output logic serial_out_ready_n_oe_n,
   output logic result_ready_n,
   input wire logic conv_valid,
   input wire logic [23:0] conv_word,
   input wire logic conv_running,
   input wire logic [6:0] conv_flags,
   output logic conv_restart,
   output logic [asrr_pkg::NUM_REGS-1:0][7:0] cfg_regs
);
   import asrr_pkg::*;

   // Two clock domains meet here. The link side runs on sclk edges and is
   // cleared by chip select; the register side runs on ref_clk and is cleared
   // by rst_b. Words that cross are either held still behind a toggle, or are
   // quasi-static settings that only move while the link is quiet.

   // Reference domain state
   // The holding copy takes every new result; the snapshot feeds the link and
   // only moves while no frame is clocking, so a byte never changes mid-shift
   logic [NUM_REGS-1:0][7:0] regs_r, regs_nxt;
   asrr_result_type snap_r, snap_nxt;
   logic [23:0] hold_r, hold_nxt;
   logic pend_r, pend_nxt;
   logic ready_n_r, ready_n_nxt;
   logic restart_r, restart_nxt;
   logic busy_s1_r, busy_s2_r, busy_s3_r;
   logic wt_s1_r, wt_s2_r, wt_s3_r;
   logic lnk_rst_n_r;

   // Link domain state
   // Bit count and shift register restart with every frame; the byte being
   // launched is kept apart from the one being received, hence full duplex
   logic [6:0] rx_sh_r, rx_sh_nxt;
   logic [2:0] rx_cnt_r, rx_cnt_nxt;
   asrr_mode_type mode_r, mode_nxt;
   logic [2:0] pos_r, pos_nxt, pos_adv;
   logic [4:0] addr_r, addr_nxt, cnt_r, cnt_nxt;
   logic [7:0] cur_r, cur_nxt, byte_in, tx_src;
   logic fresh_r, fresh_nxt;
   logic tx_bit_r, tx_nxt, started_r;
   asrr_wreq_type wreq_r, wreq_nxt;
   logic wr_tgl_r, wr_tgl_nxt, wr_fire;
   logic st_en, crc_en;
   logic [2:0] flen;

   // Check byte over the three data bytes, MSB first, register starts at zero.
   // Worked out bit-serially in one cycle; fine for 24 bits, costly if widened
   function automatic logic [7:0] crc8(input logic [23:0] d);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--) begin
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
      end
      return c;
   endfunction

   // Byte idx of the result field, skipping the status slot when disabled
   // Index 0 is the first byte on the wire. With the status byte off the
   // index is moved up by one, so the check byte always sits at slot four
   function automatic logic [7:0] field_byte(input logic [2:0] idx, input logic st,
                                             input asrr_result_type s);
      logic [2:0] j;
      j = st ? idx : idx + 3'd1;
      case (j)
         3'd0: return s.status;
         3'd1: return s.data[23:16];
         3'd2: return s.data[15:8];
         3'd3: return s.data[7:0];
         default: return s.crc;
      endcase
   endfunction

   // Out-of-map addresses read as zero
   // Reading past the end is legal and must not wrap back to offset zero,
   // or a long block read would show the identity byte again
   function automatic logic [7:0] reg_byte(input logic [4:0] a,
                                           input logic [NUM_REGS-1:0][7:0] r);
      return (a < NUM_REGS) ? r[a] : 8'h00;
   endfunction

   // Enables are quasi-static: only written by this link, settled long before use
   // A host that changes them mid-frame gets an undefined field for that
   // frame only; the next frame starts clean from byte 0
   assign st_en = regs_r[OFS_SYSTEM_CONTROL][SYS_STATUS_BYTE_ENABLE_BIT];
   assign crc_en = regs_r[OFS_SYSTEM_CONTROL][SYS_CRC_ENABLE_BIT];
   // Field length is three, four or five bytes
   assign flen = 3'(RES_DATA_BYTES) + {2'b00, st_en} + {2'b00, crc_en};

   // Byte receive and command decode on the falling SCLK edge
   // All decisions fall on the eighth falling edge of a byte, when byte_in
   // holds the whole input byte. The next output byte is chosen at that same
   // edge so that it is ready for the rising edge that follows; between
   // boundaries only the bit count and the shift register move
   always_comb begin
      byte_in = {rx_sh_r, din};
      rx_sh_nxt = {rx_sh_r[5:0], din};
      rx_cnt_nxt = rx_cnt_r + 3'd1;
      mode_nxt = mode_r;
      addr_nxt = addr_r;
      cnt_nxt = cnt_r;
      fresh_nxt = fresh_r;
      wr_fire = 1'b0;
      pos_adv = (pos_r + 3'd1 == flen) ? 3'd0 : pos_r + 3'd1;
      pos_nxt = pos_r;
      cur_nxt = cur_r;
      if (rx_cnt_r == 3'd7) begin
         fresh_nxt = 1'b0;
         pos_nxt = pos_adv;
         cur_nxt = field_byte(pos_adv, st_en, snap_r);
         unique case (mode_r)
            M_DIRECT: begin
               // Commands decoded on every byte boundary, full duplex
               // Anything else, zero bytes included, leaves the stream running
               if (byte_in == RDATA_OPCODE) begin
                  mode_nxt = M_RDATA;
                  pos_nxt = 3'd0;
                  cur_nxt = field_byte(3'd0, st_en, snap_r);
               end else if (byte_in[7:5] == PFX_REGISTER_READ_CMD) begin
                  mode_nxt = M_REGISTER_READ_CMD_HDR;
                  addr_nxt = byte_in[4:0];
                  cur_nxt = 8'h00;
               end else if (byte_in[7:5] == PFX_REGISTER_WRITE_CMD) begin
                  mode_nxt = M_REGISTER_WRITE_CMD_HDR;
                  addr_nxt = byte_in[4:0];
               end
            end
            M_RDATA: begin
               // Input bytes ignored until one full field has gone out
               // so a stray byte that looks like a command cannot cut the read
               if (pos_adv == 3'd0) begin
                  mode_nxt = M_DIRECT;
               end
            end
            M_REGISTER_READ_CMD_HDR: begin
               // Second header byte holds the count minus one
               cnt_nxt = byte_in[4:0];
               mode_nxt = M_REGISTER_READ_CMD;
               cur_nxt = reg_byte(addr_r, regs_r);
            end
            M_REGISTER_READ_CMD: begin
               // Count reaching zero ends the read; the field restarts at byte 0
               if (cnt_r == 5'd0) begin
                  mode_nxt = M_DIRECT;
                  pos_nxt = 3'd0;
                  cur_nxt = field_byte(3'd0, st_en, snap_r);
               end else begin
                  addr_nxt = addr_r + 5'd1;
                  cnt_nxt = cnt_r - 5'd1;
                  cur_nxt = reg_byte(addr_r + 5'd1, regs_r);
               end
            end
            M_REGISTER_WRITE_CMD_HDR: begin
               // Second header byte holds the count minus one
               cnt_nxt = byte_in[4:0];
               mode_nxt = M_REGISTER_WRITE_CMD;
            end
            M_REGISTER_WRITE_CMD: begin
               // Each data byte goes over on its own, so a block write takes
               // effect byte by byte; bytes past the last offset are dropped later
               wr_fire = 1'b1;
               if (cnt_r == 5'd0) begin
                  mode_nxt = M_DIRECT;
               end else begin
                  addr_nxt = addr_r + 5'd1;
                  cnt_nxt = cnt_r - 5'd1;
               end
            end
         endcase
      end
   end

   // CS high clears the whole frame state at once
   // The clear is asynchronous because sclk is stopped while deselected;
   // a frame cut short mid-byte therefore leaves nothing behind
   always_ff @(negedge sclk or posedge cs_n) begin
      if (cs_n) begin
         rx_sh_r <= 7'h00;
         rx_cnt_r <= 3'd0;
         mode_r <= M_DIRECT;
         pos_r <= 3'd0;
         addr_r <= 5'h00;
         cnt_r <= 5'h00;
         cur_r <= 8'h00;
         fresh_r <= 1'b1;
      end else begin
         rx_sh_r <= rx_sh_nxt;
         rx_cnt_r <= rx_cnt_nxt;
         mode_r <= mode_nxt;
         pos_r <= pos_nxt;
         addr_r <= addr_nxt;
         cnt_r <= cnt_nxt;
         cur_r <= cur_nxt;
         fresh_r <= fresh_nxt;
      end
   end

   // Write request crossing: word held stable, toggle announces it
   // The next data byte cannot complete in less than eight sclk periods, far
   // longer than the three ref_clk cycles the far side needs to take the word,
   // so no acknowledge is sent back
   always_comb begin
      wreq_nxt = wreq_r;
      wr_tgl_nxt = wr_tgl_r;
      if (wr_fire) begin
         wreq_nxt.addr = addr_r;
         wreq_nxt.data = byte_in;
         wr_tgl_nxt = ~wr_tgl_r;
      end
   end

   // Not cleared by CS, so a late toggle still reaches the other side
   // Its reset is lnk_rst_n_r, a flop on ref_clk, and sclk is idle then
   always_ff @(negedge sclk or negedge lnk_rst_n_r) begin
      if (!lnk_rst_n_r) begin
         wreq_r <= '0;
         wr_tgl_r <= 1'b0;
      end else begin
         wreq_r <= wreq_nxt;
         wr_tgl_r <= wr_tgl_nxt;
      end
   end

   // Launch one bit per rising edge, MSB first
   // Until the first byte boundary the output comes straight from the
   // snapshot, so the MSB is ready at the first rising edge of a frame
   always_comb begin
      tx_src = fresh_r ? field_byte(3'd0, st_en, snap_r) : cur_r;
      tx_nxt = tx_src[3'd7 - rx_cnt_r];
   end

   // Output flop idles high; started_r tells the pin mux that a frame is live
   // and, synchronised, tells the register side that the result was taken
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         tx_bit_r <= 1'b1;
         started_r <= 1'b0;
      end else begin
         tx_bit_r <= tx_nxt;
         started_r <= 1'b1;
      end
   end

   // Before the first edge the pin shows readiness; last bit then holds to CS rise
   // A polling host sees the ready level as soon as it selects, and it must
   // finish on a register whose last bit is one to leave the pin high.
   // Besides the enable, which is chip select itself, the pin mux is the one output not taken from a single flop: readiness has
   // to appear with chip select, before any sclk edge exists to launch it
   assign serial_out_ready_n = started_r ? tx_bit_r : ready_n_r;
   assign serial_out_ready_n_oe_n = cs_n;
   assign result_ready_n = ready_n_r;
   assign conv_restart = restart_r;
   assign cfg_regs = regs_r;

   // Register file, result holding and readiness
   // Writes arrive as one toggle per byte. The restart pulse is one cycle
   // long and only comes when a conversion is running and a setting that
   // matters has really changed, so rewriting the same value is harmless.
   // Only the status power flag is writable at offset 1; offset 0 never is
   always_comb begin
      regs_nxt = regs_r;
      restart_nxt = 1'b0;
      hold_nxt = hold_r;
      pend_nxt = pend_r;
      snap_nxt = snap_r;
      ready_n_nxt = ready_n_r;
      // Live flags only while the link is quiet, so a read sees a steady byte
      // A write to the status register in the same cycle takes priority
      if (!busy_s2_r) begin
         regs_nxt[OFS_DEVICE_STATUS_FLAGS][6:0] = conv_flags;
      end
      if ((wt_s2_r ^ wt_s3_r) && (wreq_r.addr < NUM_REGS)) begin
         regs_nxt[wreq_r.addr] = (regs_r[wreq_r.addr] & ~REG_WR_MASK[wreq_r.addr])
                               | (wreq_r.data & REG_WR_MASK[wreq_r.addr]);
         if (conv_running && (((regs_r[wreq_r.addr] ^ wreq_r.data)
                               & REG_RESTART_MASK[wreq_r.addr]) != 8'h00)) begin
            restart_nxt = 1'b1;
         end
      end
      // Old data is dropped on restart; a fresh result arriving now still wins
      if (restart_nxt) begin
         pend_nxt = 1'b0;
      end
      // The snapshot is taken only while the link is quiet; a result that
      // lands during a frame waits in the holding copy until chip select rises
      if (pend_r && !busy_s2_r) begin
         snap_nxt.status = regs_r[OFS_DEVICE_STATUS_FLAGS];
         snap_nxt.data = hold_r;
         snap_nxt.crc = crc8(hold_r);
         pend_nxt = 1'b0;
         ready_n_nxt = 1'b0;
      end
      if (conv_valid) begin
         hold_nxt = conv_word;
         pend_nxt = 1'b1;
      end
      // First clock of a frame seen on this side: the result counts as taken
      if (busy_s2_r && !busy_s3_r) begin
         ready_n_nxt = 1'b1;
      end
   end

   // Synchronous reset; the link side is released one cycle after rst_b
   // through lnk_rst_n_r, which only clears the write request word and its
   // toggle, since everything else on that side is cleared by chip select
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         regs_r <= REG_RESET;
         regs_r[OFS_DEVICE_IDENTITY] <= {5'h00, DEV_CODE};
         snap_r <= '0;
         hold_r <= 24'h00_0000;
         pend_r <= 1'b0;
         ready_n_r <= 1'b1;
         restart_r <= 1'b0;
         busy_s1_r <= 1'b0;
         busy_s2_r <= 1'b0;
         busy_s3_r <= 1'b0;
         wt_s1_r <= 1'b0;
         wt_s2_r <= 1'b0;
         wt_s3_r <= 1'b0;
         lnk_rst_n_r <= 1'b0;
      end else begin
         regs_r <= regs_nxt;
         snap_r <= snap_nxt;
         hold_r <= hold_nxt;
         pend_r <= pend_nxt;
         ready_n_r <= ready_n_nxt;
         restart_r <= restart_nxt;
         busy_s1_r <= started_r;
         busy_s2_r <= busy_s1_r;
         busy_s3_r <= busy_s2_r;
         wt_s1_r <= wr_tgl_r;
         wt_s2_r <= wt_s1_r;
         wt_s3_r <= wt_s2_r;
         lnk_rst_n_r <= 1'b1;
      end
   end
endmodule

/* File: asrr_host.sv */
module asrr_host (
   output logic sclk,
   output logic cs_n,
   output logic din,
   input wire logic sdo
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle link: clock low and still, chip select high
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      din = 1'h0;
   end
   // Select change with a gap, so the clock never runs outside a frame
   task automatic sel(input logic v);
      #103 cs_n = v;
      #100;
   endtask
   // One byte MSB first; din moves on rise, sdo is read on fall
   task automatic xb(input logic [7:0] t, output logic [7:0] r);
      for (int i = 7; i >= 0; i--) begin
         sclk = 1'h1;
         din = t[i];
         #32 sclk = 1'h0;
         r[i] = sdo;
         #32;
      end
      din = 1'h0; // Low between bytes so nothing extra decodes
   endtask
endmodule

/* File: asrr_checker.sv */
module asrr_checker #(
   parameter logic [2:0] DEV_CODE = 3'h5
) (
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic cs_n,
   input wire logic serial_out_ready_n,
   input wire logic serial_out_ready_n_oe_n,
   input wire logic result_ready_n,
   input wire logic conv_valid,
   input wire logic conv_running,
   input wire logic conv_restart,
   input wire logic [asrr_pkg::NUM_REGS-1:0][7:0] cfg_regs
);
   import asrr_pkg::*;
   // One domain, so clock and reset are given once
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   a_pin_released: assert property (serial_out_ready_n_oe_n == cs_n)
      else $error("shared pin enable differs from select");
   a_select_shows_ready: assert property ($fell(cs_n) |-> serial_out_ready_n == result_ready_n)
      else $error("shared pin does not show readiness on select");
   a_ready_on_result: assert property (conv_valid && cs_n |-> ##[1:4] !result_ready_n)
      else $error("ready pin did not fall after a result");
   a_restart_needs_run: assert property (conv_restart |-> conv_running || $past(conv_running))
      else $error("restart without a running conversion");
   a_restart_single: assert property (conv_restart |=> !conv_restart)
      else $error("restart longer than one cycle");
   a_restart_on_change: assert property (conv_running && $past(conv_running)
      && ((cfg_regs ^ $past(cfg_regs)) & REG_RESTART_MASK) != '0 |-> ##[0:1] conv_restart)
      else $error("changed setting gave no restart");
   a_identity_fixed: assert property (cfg_regs[0] == {5'h00, DEV_CODE})
      else $error("identity register changed");
   a_power_flag_sticky: assert property (!cfg_regs[1][7] |=> !cfg_regs[1][7])
      else $error("power flag set again without reset");
   a_reset_loads: assert property (rst_b && !$past(rst_b) |-> result_ready_n && !conv_restart
      && cfg_regs[NUM_REGS-1:1] == REG_RESET[NUM_REGS-1:1])
      else $error("reset values wrong");
endmodule
bind asrr_top asrr_checker #(.DEV_CODE(DEV_CODE)) u_asrr_checker (
   .ref_clk(ref_clk),
   .rst_b(rst_b),
   .cs_n(cs_n),
   .serial_out_ready_n(serial_out_ready_n),
   .serial_out_ready_n_oe_n(serial_out_ready_n_oe_n),
   .result_ready_n(result_ready_n),
   .conv_valid(conv_valid),
   .conv_running(conv_running),
   .conv_restart(conv_restart),
   .cfg_regs(cfg_regs)
);

/* File: tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import asrr_pkg::*;
   localparam logic [2:0] ID_CODE = 3'h5; // Arbitrary identity value
   localparam logic [7:0] RD_OPC = 8'h12;
   logic ref_clk = 1'h0;
   logic rst_b = 1'h0;
   logic conv_valid = 1'h0;
   logic conv_running = 1'h0;
   logic [23:0] conv_word = 24'h00_0000;
   logic [6:0] conv_flags = 7'h00;
   logic sclk, cs_n, din, serial_out_ready_n, serial_out_ready_n_oe_n;
   logic result_ready_n, conv_restart;
   logic [NUM_REGS-1:0][7:0] cfg_regs;
   logic [7:0] r;
   logic last_so = 1'h0;
   int err_count = 0;
   int total_checks = 0;
   int n_rst = 0;
   // Released pin shows the inverse of its last level, never a stale copy
   wire sdo_w = serial_out_ready_n_oe_n ? ~last_so : serial_out_ready_n;
   always #25 ref_clk = ~ref_clk;
   // Last driven level of the shared pin, and a count of restart pulses
   always @(posedge ref_clk) begin
      if (!serial_out_ready_n_oe_n)
         last_so <= serial_out_ready_n;
      if (conv_restart === 1'h1)
         n_rst <= n_rst + 1;
   end
   asrr_host u_asrr_host (.sclk(sclk), .cs_n(cs_n), .din(din), .sdo(sdo_w));
   asrr_top #(.DEV_CODE(ID_CODE), .RDATA_OPCODE(RD_OPC)) u_asrr_top (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .sclk(sclk),
      .cs_n(cs_n),
      .din(din),
      .serial_out_ready_n(serial_out_ready_n),
      .serial_out_ready_n_oe_n(serial_out_ready_n_oe_n),
      .result_ready_n(result_ready_n),
      .conv_valid(conv_valid),
      .conv_word(conv_word),
      .conv_running(conv_running),
      .conv_flags(conv_flags),
      .conv_restart(conv_restart),
      .cfg_regs(cfg_regs)
   );
   task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value at %0t: %s got %h want %h", $time, m, got, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Byte exchange with a compare of what came back
   task automatic xc(input logic [7:0] t, input logic [7:0] e, input string m);
      u_asrr_host.xb(t, r);
      chk(r, e, m);
   endtask
   function automatic logic [7:0] crc8(input logic [23:0] w);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 23; i >= 0; i--)
         c = {c[6:0], 1'h0} ^ ((c[7] ^ w[i]) ? 8'h07 : 8'h00);
      return c;
   endfunction
   // New result after the idle flag has settled; the wait is bounded
   task automatic pulse(input logic [23:0] w, input bit wt);
      repeat (10) @(negedge ref_clk);
      conv_word = w;
      conv_valid = 1'h1;
      @(negedge ref_clk);
      conv_valid = 1'h0;
      for (int n = 0; wt && n < 20 && result_ready_n !== 1'h0; n++)
         @(negedge ref_clk);
      if (wt)
         chk({7'h00, result_ready_n}, 8'h00, "ready");
      if (wt && result_ready_n !== 1'h0)
         wrap_up();
   endtask
   // Whole map in one block read, one place past the end
   task automatic s_reset();
      u_asrr_host.sel(1'h0);
      u_asrr_host.xb(8'h20, r);
      u_asrr_host.xb(8'h12, r);
      for (int i = 0; i <= NUM_REGS; i++)
         xc(8'h00, i == 0 ? {5'h00, ID_CODE} : i < NUM_REGS ? REG_RESET[i] : 8'h00, "map");
      u_asrr_host.sel(1'h1);
   endtask
   // Direct read wraps after three bytes; select alone shows readiness
   task automatic s_direct();
      pulse(24'h5a_c3e1, 1);
      u_asrr_host.sel(1'h0);
      chk({7'h00, sdo_w}, 8'h00, "ready pin");
      xc(8'h00, 8'h5a, "d0");
      xc(8'h00, 8'hc3, "d1");
      xc(8'h00, 8'he1, "d2");
      xc(8'h00, 8'h5a, "wrap");
      u_asrr_host.sel(1'h1);
      chk({7'h00, serial_out_ready_n_oe_n}, 8'h01, "release");
      repeat (10) @(negedge ref_clk);
      u_asrr_host.sel(1'h0);
      chk({7'h00, sdo_w}, 8'h01, "no result");
      u_asrr_host.sel(1'h1);
   endtask
   // Write during a direct read: stream intact, restart only for a changed byte
   task automatic s_register_write_cmd();
      int b;
      @(negedge ref_clk);
      conv_running = 1'h1;
      pulse(24'h3c_96f0, 1);
      b = n_rst;
      u_asrr_host.sel(1'h0);
      xc(8'h42, 8'h3c, "w0");
      xc(8'h01, 8'h96, "w1");
      xc(8'h07, 8'hf0, "w2");
      repeat (6) @(negedge ref_clk);
      chk(cfg_regs[2], 8'h07, "early");
      xc(8'h00, 8'h3c, "w wrap");
      u_asrr_host.sel(1'h1);
      // Let the last, unchanged byte land so a wrong restart would be counted
      repeat (4) @(negedge ref_clk);
      chk(8'(n_rst - b), 8'h01, "restarts");
      @(negedge ref_clk);
      conv_running = 1'h0;
   endtask
   // Read-data with status and check byte; a command inside the field is ignored
   task automatic s_rdata();
      u_asrr_host.sel(1'h0);
      u_asrr_host.xb(8'h49, r);
      u_asrr_host.xb(8'h00, r);
      u_asrr_host.xb(8'h13, r);
      u_asrr_host.sel(1'h1);
      @(negedge ref_clk);
      conv_flags = 7'h2a;
      pulse(24'h81_7e24, 1);
      u_asrr_host.sel(1'h0);
      u_asrr_host.xb(RD_OPC, r);
      pulse(24'h12_3456, 0);
      xc(8'h00, 8'haa, "status");
      xc(8'h20, 8'h81, "r0");
      xc(8'h00, 8'h7e, "r1");
      xc(8'h00, 8'h24, "r2");
      xc(8'h00, crc8(24'h81_7e24), "crc");
      xc(8'h00, 8'haa, "r wrap");
      u_asrr_host.sel(1'h1);
   endtask
   // Register read inside a direct read; a last bit of one leaves the pin high
   task automatic s_abort();
      repeat (10) @(negedge ref_clk);
      u_asrr_host.sel(1'h0);
      xc(8'h22, 8'haa, "a0");
      u_asrr_host.xb(8'h00, r);
      xc(8'h00, 8'h07, "abort");
      chk({7'h00, sdo_w}, 8'h01, "poll high");
      u_asrr_host.sel(1'h1);
   endtask
   // Power flag cleared by a write, then read back beside the live flags
   task automatic s_clear();
      u_asrr_host.sel(1'h0);
      u_asrr_host.xb(8'h41, r);
      u_asrr_host.xb(8'h00, r);
      u_asrr_host.xb(8'h00, r);
      u_asrr_host.xb(8'h21, r);
      u_asrr_host.xb(8'h00, r);
      xc(8'h00, 8'h2a, "flag read");
      u_asrr_host.sel(1'h1);
      chk(cfg_regs[1], 8'h2a, "flag reg");
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (16) @(negedge ref_clk);
      rst_b = 1'h1;
      repeat (2) @(negedge ref_clk);
      s_reset();
      s_direct();
      s_register_write_cmd();
      s_rdata();
      s_abort();
      s_clear();
      wrap_up();
   end
endmodule
